// ### core/media_converter_strap_config.sv
/*
 * Strap capture, EEPROM override and decode of the operating mode, port,
 * loopback, switch MII and queue service settings, with an Avalon-MM
 * register slave.
 * Assumes strap pins are asynchronous and settle while sys_rst is high,
 * and that the EEPROM loader and switch logic share clk.
 */
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps

module media_converter_strap_config (
    input wire logic clk,
    input wire logic sys_rst,
    input wire strap_config_pkg::strap_s strap_pins,
    input wire logic power_down_detect_n,
    input wire logic ee_valid,
    input wire strap_config_pkg::strap_s ee_data,
    input wire logic [1:0] an_pause_result,
    input wire logic converter_fault,
    input wire strap_config_pkg::lb_frame_s lb_frame,
    input wire logic q_slot,
    input wire logic q_hi_pend,
    input wire logic q_lo_pend,
    input wire logic oam_ack,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output strap_config_pkg::mode_cfg_s mode_cfg,
    output strap_config_pkg::port_cfg_s port1_cfg,
    output strap_config_pkg::port_cfg_s port2_cfg,
    output strap_config_pkg::mii_cfg_s mii_cfg,
    output logic missing_link_en,
    output logic fast_backoff_en,
    output logic port2_auto_cross_en,
    output logic port2_straight,
    output logic fiber_port_status,
    output logic loopback_at_port2,
    output logic lb_pass,
    output logic lb_drop,
    output logic oam_req,
    output logic term_state_bit0,
    output logic q_serve_hi,
    output logic q_serve_lo,
    output logic mii_tx_clock_o,
    output logic mii_tx_clock_oe,
    output logic mii_rx_clock_o,
    output logic mii_rx_clock_oe
);
    import strap_config_pkg::*;

    // ----------------
    // Functions
    // ----------------
    // Weight of the high queue per low frame; zero means strict
    function automatic logic [3:0] service_ratio(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        unique case (sel)
            2'b00: r = 4'h0;
            2'b01: r = `RATIO_10_TO_1;
            2'b10: r = `RATIO_5_TO_1;
            2'b11: r = `RATIO_2_TO_1;
        endcase
        return r;
    endfunction

    // Port settings from its straps and the negotiated pause result
    function automatic port_cfg_s port_decode(input logic an,
            input logic spd, input logic dpx, input logic ffc,
            input logic adv, input logic an_pause);
        port_cfg_s p;
        p.autoneg_en = an;
        p.speed_100 = spd;
        p.duplex_full = dpx;
        p.advertise_pause = adv;
        p.pause_en = ffc | an_pause;
        return p;
    endfunction

    // ----------------
    // Pin synchronisers
    // ----------------
    strap_s pins_meta_q;
    strap_s pins_q;
    logic pdd_meta_q;
    logic pdd_q;
    logic pdd_last_q;

    // Two stages; only the second is read by anything else
    always_ff @(posedge clk) begin
        pins_meta_q <= strap_pins;
        pins_q <= pins_meta_q;
        pdd_meta_q <= power_down_detect_n;
        pdd_q <= pdd_meta_q;
    end

    // ----------------
    // Strap capture and EEPROM override
    // ----------------
    strap_s strap_q;
    strap_s strap_d;
    logic ee_loaded_q;

    // Spared fields keep their pin values when the keep strap is high
    always_comb begin
        strap_d = ee_data;
        if (strap_q.strap_override_keep) begin
            strap_d.port2_autoneg_en = strap_q.port2_autoneg_en;
            strap_d.port2_speed_sel = strap_q.port2_speed_sel;
            strap_d.port2_duplex_sel = strap_q.port2_duplex_sel;
            strap_d.missing_link_en = strap_q.missing_link_en;
            strap_d.strap_override_keep = 1'b1;
        end
    end

    // Sampled every cycle of reset; the last sample before release holds
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_q <= pins_q;
        end else if (ee_valid) begin
            strap_q <= strap_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ee_loaded_q <= 1'b0;
        end else if (ee_valid) begin
            ee_loaded_q <= 1'b1;
        end
    end

    // ----------------
    // Operating mode decode
    // ----------------
    mode_cfg_s mode_d;

    always_comb begin
        mode_d = '0;
        unique case ({strap_q.mode_sel_hi, strap_q.mode_sel_lo})
            2'b00: begin
                mode_d.mii_port_en = 1'b1;
                mode_d.three_macs = 1'b1;
            end
            2'b01: begin
                mode_d.conv_en = 1'b1;
                mode_d.center_en = 1'b1;
                mode_d.port1_fiber_only = 1'b1;
                mode_d.mii_port_en = 1'b1;
                mode_d.three_macs = 1'b1;
            end
            2'b10: begin
                mode_d.conv_en = 1'b1;
                mode_d.terminal_en = 1'b1;
                mode_d.port1_fiber_only = 1'b1;
            end
            2'b11: begin
                mode_d.conv_en = 1'b1;
                mode_d.terminal_en = 1'b1;
                mode_d.port1_fiber_only = 1'b1;
                mode_d.mii_port_en = 1'b1;
                mode_d.three_macs = 1'b1;
            end
        endcase
    end

    // ----------------
    // Port, crossover and MII settings, all registered
    // ----------------
    mii_cfg_s mii_d;

    always_comb begin
        mii_d.mode = mii_mode_e'({strap_q.mii_cfg_hi,
                                  strap_q.mii_cfg_lo});
        mii_d.pause_full_en = strap_q.mii_rx_bit3_strap;
        mii_d.half_duplex = strap_q.mii_rx_bit2_strap;
        mii_d.speed_10 = strap_q.mii_rx_bit1_strap;
        // Long limit covers both tag states when pulled down
        if (strap_q.mii_rx_bit0_strap) begin
            mii_d.max_len_tagged = `MAX_LEN_TAGGED;
            mii_d.max_len_untagged = `MAX_LEN_UNTAGGED;
        end else begin
            mii_d.max_len_tagged = `MAX_LEN_LONG;
            mii_d.max_len_untagged = `MAX_LEN_LONG;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_cfg <= '0;
            port1_cfg <= '0;
            port2_cfg <= '0;
            mii_cfg <= '0;
        end else begin
            mode_cfg <= mode_d;
            port1_cfg <= port_decode(strap_q.port1_autoneg_en,
                strap_q.port1_speed_sel, strap_q.port1_duplex_sel,
                strap_q.port1_force_pause, strap_q.advertise_pause,
                an_pause_result[0]);
            port2_cfg <= port_decode(strap_q.port2_autoneg_en,
                strap_q.port2_speed_sel, strap_q.port2_duplex_sel,
                strap_q.port2_force_pause, strap_q.advertise_pause,
                an_pause_result[1]);
            mii_cfg <= mii_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            missing_link_en <= 1'b0;
            fast_backoff_en <= 1'b0;
            port2_auto_cross_en <= 1'b1;
            port2_straight <= 1'b0;
        end else begin
            missing_link_en <= strap_q.missing_link_en;
            fast_backoff_en <= strap_q.fast_backoff_en;
            port2_auto_cross_en <= ~strap_q.port2_auto_cross_dis;
            // Manual choice only matters with auto crossover off
            port2_straight <= strap_q.port2_auto_cross_dis
                              & strap_q.port2_cross_sel;
        end
    end

    // ----------------
    // MII clocks
    // ----------------
    logic [1:0] mii_div_q;
    logic mii_clk_q;
    logic mii_drive;

    // Both PHY roles own the clocks; MAC role and off leave them input
    assign mii_drive = (mii_cfg.mode == MII_PHY_ROLE)
                       | (mii_cfg.mode == MII_PHY_SERIAL);

    // Divided from clk; true line rates come from a PLL outside
    always_ff @(posedge clk) begin
        if (sys_rst || !mii_drive) begin
            mii_div_q <= 2'h0;
            mii_clk_q <= 1'b0;
        end else if (mii_div_q == `MII_CLK_HALF) begin
            mii_div_q <= 2'h0;
            mii_clk_q <= ~mii_clk_q;
        end else begin
            mii_div_q <= mii_div_q + 2'h1;
        end
    end

    assign mii_tx_clock_o = mii_clk_q;
    assign mii_rx_clock_o = mii_clk_q;
    assign mii_tx_clock_oe = mii_drive;
    assign mii_rx_clock_oe = mii_drive;

    // ----------------
    // Converter loopback and fiber status
    // ----------------
    logic loop_en_q;
    logic lb_active;
    logic lb_bad;

    // High point setting is reserved, so no loopback is run there
    assign lb_active = loop_en_q & mode_cfg.conv_en
                       & ~strap_q.loopback_point_sel;
    assign lb_bad = lb_frame.crc_err | lb_frame.undersize
                    | lb_frame.oversize;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loopback_at_port2 <= 1'b0;
            lb_pass <= 1'b0;
            lb_drop <= 1'b0;
            fiber_port_status <= 1'b1;
        end else begin
            loopback_at_port2 <= lb_active;
            lb_drop <= lb_active & lb_frame.valid & (lb_frame.is_oam
                | (strap_q.loopback_error_drop & lb_bad));
            lb_pass <= lb_active & lb_frame.valid & ~lb_frame.is_oam
                & ~(strap_q.loopback_error_drop & lb_bad);
            fiber_port_status <= ~(lb_active | converter_fault);
        end
    end

    // ----------------
    // Terminal state OAM request
    // ----------------
    logic pdd_fall;
    logic [7:0] oam_count_q;

    assign pdd_fall = pdd_last_q & ~pdd_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pdd_last_q <= 1'b1;
        end else begin
            pdd_last_q <= pdd_q;
        end
    end

    // A new fall in the acknowledge cycle keeps the request up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oam_req <= 1'b0;
            term_state_bit0 <= 1'b0;
        end else if (pdd_fall && mode_cfg.terminal_en) begin
            oam_req <= 1'b1;
            term_state_bit0 <= 1'b1;
        end else if (oam_ack) begin
            oam_req <= 1'b0;
        end
    end

    // Wraps at 255; software takes differences
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oam_count_q <= 8'h00;
        end else if (pdd_fall && mode_cfg.terminal_en) begin
            oam_count_q <= oam_count_q + 8'h01;
        end
    end

    // ----------------
    // Split queue service
    // ----------------
    logic [3:0] ratio;
    logic [3:0] hi_run_q;
    logic take_hi;

    assign ratio = service_ratio({strap_q.queue_service_hi,
                                  strap_q.queue_service_lo});
    // Strict mode never lets low go ahead of a waiting high frame
    assign take_hi = q_hi_pend
                     & ((ratio == 4'h0) | (hi_run_q < ratio)
                        | ~q_lo_pend);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hi_run_q <= 4'h0;
            q_serve_hi <= 1'b0;
            q_serve_lo <= 1'b0;
        end else begin
            q_serve_hi <= q_slot & take_hi;
            q_serve_lo <= q_slot & ~take_hi & q_lo_pend;
            if (q_slot && take_hi && hi_run_q != 4'hF) begin
                hi_run_q <= hi_run_q + 4'h1;
            end else if (q_slot && !take_hi && q_lo_pend) begin
                hi_run_q <= 4'h0;
            end
        end
    end

    // ----------------
    // Avalon-MM slave
    // ----------------
    logic ack_q;
    logic [31:0] rd_d;
    logic [31:0] status_word;

    assign status_word = {20'h0, 2'b00, mode_cfg.mii_port_en,
        mode_cfg.terminal_en, mode_cfg.center_en, mode_cfg.conv_en,
        lb_active, ee_loaded_q, fiber_port_status, oam_req};

    // One wait cycle on every access, so read data come from a flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // Unmapped offsets read as zero
    always_comb begin
        rd_d = 32'h0;
        unique case (avs_address)
            `REG_STRAP_LIVE: rd_d = {6'h00, strap_q};
            `REG_CTRL: rd_d = {31'h0, loop_en_q};
            `REG_STATUS: rd_d = status_word;
            `REG_OAM_COUNT: rd_d = {24'h0, oam_count_q};
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rd_d;
        end
    end

    // Write lands at the edge where waitrequest is seen low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loop_en_q <= `CTRL_RESET;
        end else if (avs_write && ack_q && avs_address == `REG_CTRL
                     && avs_byteenable[0]) begin
            loop_en_q <= avs_writedata[`CTRL_LOOPBACK_BIT];
        end
    end
endmodule

// ### core/strap_config_defs.svh
/*
 * Offsets, reset values, frame limits and service ratios of the strap
 * configuration loader.
 * Assumes inclusion by bare name from the package; the core module sees its macros through it.
 */
`ifndef STRAP_CONFIG_DEFS_SVH
`define STRAP_CONFIG_DEFS_SVH

// ----------------
// Register byte offsets (word aligned)
// ----------------
`define REG_STRAP_LIVE 4'h0
`define REG_CTRL 4'h4
`define REG_STATUS 4'h8
`define REG_OAM_COUNT 4'hC

// ----------------
// Field positions and reset values
// ----------------
`define CTRL_LOOPBACK_BIT 0
`define CTRL_RESET 1'b0
`define STAT_OAM_PEND_BIT 0
`define STAT_FIBER_OK_BIT 1
`define STAT_EE_LOADED_BIT 2
`define STAT_LOOPBACK_BIT 3
`define STAT_MODE_LSB 4

// ----------------
// Frame limits in bytes
// ----------------
`define MAX_LEN_LONG 11'd1536
`define MAX_LEN_TAGGED 11'd1522
`define MAX_LEN_UNTAGGED 11'd1518

// ----------------
// High to low service ratios and clock divider
// ----------------
`define RATIO_10_TO_1 4'hA
`define RATIO_5_TO_1 4'h5
`define RATIO_2_TO_1 4'h2
`define MII_CLK_HALF 2'h1

`endif

// ### core/strap_config_pkg.sv
/*
 * Types shared by the strap configuration loader and its bench.
 * Assumes the constants header sits beside it.
 */
package strap_config_pkg;
`include "strap_config_defs.svh"

    // Raw strap levels, one bit per pin
    typedef struct packed {
        logic mode_sel_hi;
        logic mode_sel_lo;
        logic advertise_pause;
        logic port1_autoneg_en;
        logic port1_speed_sel;
        logic port1_duplex_sel;
        logic port1_force_pause;
        logic port2_autoneg_en;
        logic port2_speed_sel;
        logic port2_duplex_sel;
        logic port2_force_pause;
        logic loopback_error_drop;
        logic loopback_point_sel;
        logic strap_override_keep;
        logic port2_auto_cross_dis;
        logic port2_cross_sel;
        logic missing_link_en;
        logic fast_backoff_en;
        logic mii_rx_bit3_strap;
        logic mii_rx_bit2_strap;
        logic mii_rx_bit1_strap;
        logic mii_rx_bit0_strap;
        logic mii_cfg_hi;
        logic mii_cfg_lo;
        logic queue_service_hi;
        logic queue_service_lo;
    } strap_s;

    // Decoded operating mode
    typedef struct packed {
        logic conv_en;
        logic center_en;
        logic terminal_en;
        logic port1_fiber_only;
        logic mii_port_en;
        logic three_macs;
    } mode_cfg_s;

    // Per copper/fiber port settings
    typedef struct packed {
        logic autoneg_en;
        logic speed_100;
        logic duplex_full;
        logic advertise_pause;
        logic pause_en;
    } port_cfg_s;

    typedef enum logic [1:0] {
        MII_OFF,
        MII_PHY_ROLE,
        MII_MAC_ROLE,
        MII_PHY_SERIAL
    } mii_mode_e;

    // Switch MII port settings
    typedef struct packed {
        mii_mode_e mode;
        logic pause_full_en;
        logic half_duplex;
        logic speed_10;
        logic [10:0] max_len_tagged;
        logic [10:0] max_len_untagged;
    } mii_cfg_s;

    // Frame seen by the loopback path
    typedef struct packed {
        logic valid;
        logic is_oam;
        logic crc_err;
        logic undersize;
        logic oversize;
    } lb_frame_s;
endpackage

// ### tb/strap_cfg_sva.sv
/*
 * Checker of the strap loader outputs against its inputs.
 * Assumes it is bound to the loader top, one clock, reset sys_rst.
 */
`timescale 1ns/1ps
module strap_cfg_sva (
    input logic clk,
    input logic sys_rst,
    input strap_config_pkg::lb_frame_s lb_frame,
    input logic converter_fault,
    input logic oam_ack,
    input logic q_slot,
    input logic q_hi_pend,
    input logic q_lo_pend,
    input strap_config_pkg::mode_cfg_s mode_cfg,
    input strap_config_pkg::mii_cfg_s mii_cfg,
    input logic fiber_port_status,
    input logic lb_pass,
    input logic lb_drop,
    input logic oam_req,
    input logic term_state_bit0,
    input logic q_serve_hi,
    input logic q_serve_lo,
    input logic mii_tx_clock_oe,
    input logic mii_rx_clock_oe
);
    import strap_config_pkg::*;
    logic live_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Decoded outputs are only due one edge after release
    always_ff @(posedge clk) begin
        live_q <= !sys_rst;
    end
    a_term_kind: assert property (live_q && mode_cfg.terminal_en |->
        mode_cfg.conv_en && !mode_cfg.center_en
        && mode_cfg.port1_fiber_only) else $error("terminal decode");
    a_mac_count: assert property (live_q |-> mode_cfg.three_macs ==
        mode_cfg.mii_port_en && (mode_cfg.mii_port_en
        || mode_cfg.terminal_en)) else $error("mac count");
    a_mii_clk_oe: assert property (mii_rx_clock_oe == mii_tx_clock_oe
        && mii_tx_clock_oe == (mii_cfg.mode inside {MII_PHY_ROLE,
        MII_PHY_SERIAL})) else $error("mii clock drive");
    a_frame_len: assert property (live_q |->
        {mii_cfg.max_len_tagged, mii_cfg.max_len_untagged} inside
        {22'h2F95EE, 22'h300600}) else $error("frame limit");
    a_lb_excl: assert property (!(lb_pass && lb_drop))
        else $error("pass and drop");
    a_lb_no_oam: assert property (lb_pass |->
        $past(lb_frame.valid && !lb_frame.is_oam))
        else $error("bad pass");
    a_lb_status: assert property (lb_pass || lb_drop |->
        !fiber_port_status) else $error("status in loop");
    a_fault_low: assert property ($rose(converter_fault) |->
        ##[1:2] !fiber_port_status) else $error("fault status");
    a_oam_term: assert property ($rose(oam_req) |-> mode_cfg.terminal_en)
        else $error("oam outside terminal");
    a_oam_hold: assert property (oam_req && !oam_ack |=> oam_req)
        else $error("oam dropped");
    a_s0_set: assert property (oam_req |-> term_state_bit0)
        else $error("s0 clear");
    a_serve_hi: assert property (q_serve_hi |-> !q_serve_lo
        && $past(q_slot && q_hi_pend)) else $error("hi grant");
    a_serve_lo: assert property (q_serve_lo |->
        $past(q_slot && q_lo_pend)) else $error("lo grant");
    a_slot_ans: assert property (q_slot && (q_hi_pend || q_lo_pend)
        |=> q_serve_hi || q_serve_lo) else $error("no grant");
endmodule

bind media_converter_strap_config strap_cfg_sva u_sva (.clk, .sys_rst,
    .lb_frame, .converter_fault, .oam_ack, .q_slot, .q_hi_pend,
    .q_lo_pend, .mode_cfg, .mii_cfg, .fiber_port_status, .lb_pass,
    .lb_drop, .oam_req, .term_state_bit0, .q_serve_hi, .q_serve_lo,
    .mii_tx_clock_oe, .mii_rx_clock_oe);

// ### tb/oam_partner.sv
/*
 * Far-side OAM sender: acknowledges each request ack_dly cycles after it first sees it, ack_dly+1 after it rises.
 * Assumes the loader's clock.
 */
`timescale 1ns/1ps
module oam_partner (
    input wire logic clk,
    input wire logic oam_req,
    input wire logic [3:0] ack_dly,
    output logic oam_ack = 1'b0
);
    logic [3:0] cnt_q = 4'h0;
    // A slow ack proves the request is held meanwhile
    always @(posedge clk) begin
        oam_ack <= 1'b0;
        if (!oam_req || oam_ack)
            cnt_q <= 4'h0;
        else if (cnt_q == ack_dly)
            oam_ack <= 1'b1;
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// ### tb/media_converter_strap_config_tb.sv
/*
 * Bench of the strap loader: straps per reset, bus, loopback, OAM, EEPROM.
 * Assumes the checker and the OAM partner are compiled beside it.
 */
`timescale 1ns/1ps
module media_converter_strap_config_tb;
    import strap_config_pkg::*;
    logic clk, sys_rst, pdd_n, ee_valid, fault, q_slot, q_hi, q_lo, p;
    logic oam_ack, avs_read, avs_write, avs_waitrequest, lap, fst;
    logic missing_link_en, fast_backoff_en, port2_auto_cross_en;
    logic port2_straight, lb_pass, lb_drop, oam_req, term_state_bit0;
    logic q_serve_hi, q_serve_lo, lo_seen;
    logic [1:0] an;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    strap_s pins, ee, s;
    lb_frame_s lb;
    mode_cfg_s mode_cfg;
    port_cfg_s port1_cfg, port2_cfg;
    mii_cfg_s mii_cfg;
    int errors, n_tests, run, m, k;
    logic [5:0] mtab [4] = '{6'h03, 6'h37, 6'h2C, 6'h2F};

    media_converter_strap_config DUT (
        .clk, .sys_rst, .strap_pins(pins), .power_down_detect_n(pdd_n),
        .ee_valid, .ee_data(ee), .an_pause_result(an),
        .converter_fault(fault), .lb_frame(lb), .q_slot, .q_hi_pend(q_hi),
        .q_lo_pend(q_lo), .oam_ack, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .mode_cfg, .port1_cfg, .port2_cfg, .mii_cfg, .missing_link_en,
        .fast_backoff_en, .port2_auto_cross_en, .port2_straight,
        .fiber_port_status(fst), .loopback_at_port2(lap), .lb_pass,
        .lb_drop, .oam_req, .term_state_bit0, .q_serve_hi, .q_serve_lo,
        .mii_tx_clock_o(), .mii_tx_clock_oe(), .mii_rx_clock_o(),
        .mii_rx_clock_oe()
    );
    oam_partner P (.clk(clk), .oam_req(oam_req), .ack_dly(4'h6),
        .oam_ack(oam_ack));

    // ----------------
    // Clock, tasks and watchdog
    // ----------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Request held to the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, be,
                       input logic [31:0] d);
        int t;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= d;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 30);
        if (t >= 30)
            chk(0, 1, "waitrequest");
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Straps only count while reset is high
    task automatic do_reset(input strap_s v);
        @(posedge clk);
        pins <= v;
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        {sys_rst, pdd_n, ee_valid, fault, q_slot, q_hi, q_lo} = 7'h60;
        {pins, ee, lb, an, avs_read, avs_write} = '0;
        {avs_address, avs_byteenable, avs_writedata} = '0;
        errors = 0;
        n_tests = 0;
        // Every mode, MII mode and queue ratio, one reset each
        for (m = 0; m < 4; m++) begin
            s = '0;
            {s.mode_sel_hi, s.mode_sel_lo} = m[1:0];
            {s.queue_service_hi, s.queue_service_lo} = m[1:0];
            {s.mii_cfg_hi, s.mii_cfg_lo} = m[1:0];
            {s.mii_rx_bit3_strap, s.mii_rx_bit2_strap} = m[1:0];
            {s.mii_rx_bit1_strap, s.mii_rx_bit0_strap} = m[1:0];
            {s.port1_speed_sel, s.port1_duplex_sel} = m[1:0];
            {s.port1_force_pause, s.advertise_pause} = m[1:0];
            {s.fast_backoff_en, s.port2_auto_cross_dis} = m[1:0];
            s.port2_cross_sel = m[1];
            do_reset(s);
            chk(mode_cfg, mtab[m], "mode");
            chk(port1_cfg, {1'b0, m[1:0], m[0], m[1]},
                "p1");
            chk(mii_cfg, {m[1:0], m[1:0], m[1],
                m[0] ? 22'h2F95EE : 22'h300600},
                "mii");
            chk({port2_auto_cross_en, fast_backoff_en}, {!m[0], m[1]},
                "x");
            if (m[0])
                chk(port2_straight, m[1], "straight");
            run = 0;
            lo_seen = 1'b0;
            q_hi <= 1'b1;
            q_lo <= 1'b1;
            repeat (12) begin
                @(posedge clk);
                q_slot <= 1'b1;
                @(posedge clk);
                q_slot <= 1'b0;
                @(negedge clk);
                if (q_serve_lo === 1'b1)
                    lo_seen = 1'b1;
                else if (!lo_seen && q_serve_hi === 1'b1)
                    run++;
            end
            chk(run, m == 0 ? 12 : m == 1 ? 10 : m == 2 ? 5 : 2,
                "run");
            pins <= ~s;
            bus(1'b0, 4'h0, 4'hF, 32'h0);
            chk(rd, {6'h0, s}, "live");
            chk(mode_cfg, mtab[m], "held");
        end
        // Terminal mode: power-down fall sends the indication
        s = '0;
        {s.mode_sel_hi, s.mode_sel_lo} = 2'b11;
        do_reset(s);
        pdd_n <= 1'b0;
        repeat (8) @(negedge clk);
        chk({oam_req, term_state_bit0}, 2'b11, "oam");
        for (k = 0; k < 30 && oam_req !== 1'b0; k++)
            @(negedge clk);
        pdd_n <= 1'b1;
        bus(1'b0, 4'hC, 4'hF, 32'h0);
        chk(rd, 32'h1, "oam count");
        // Center mode loopback, error drop strap low then high
        for (k = 0; k < 10; k++) begin
            if (k % 5 == 0) begin
                s = '0;
                s.mode_sel_lo = 1'b1;
                s.loopback_error_drop = k / 5;
                do_reset(s);
                pdd_n <= 1'b0;
                bus(1'b1, 4'h4, 4'h0, 32'h1);
                bus(1'b0, 4'h4, 4'hF, 32'h0);
                chk(rd, 32'h0, "ctrl lane");
                bus(1'b1, 4'h4, 4'h1, 32'h1);
                bus(1'b0, 4'h8, 4'hF, 32'h0);
                chk(rd, 32'hB8, "status");
            end
            @(posedge clk);
            lb <= 5'h10 | (5'h10 >> (k % 5));
            @(posedge clk);
            lb <= '0;
            @(negedge clk);
            p = k % 5 == 0 || (k < 5 && k != 1);
            chk({lb_pass, lb_drop, fst, lap}, {p, !p, 2'b01},
                "lb");
        end
        chk(oam_req, 1'b0, "center oam");
        pdd_n <= 1'b1;
        bus(1'b1, 4'h4, 4'h1, 32'h0);
        fault <= 1'b1;
        repeat (3) @(negedge clk);
        chk(fst, 1'b0, "fault");
        fault <= 1'b0;
        repeat (3) @(negedge clk);
        chk(fst, 1'b1, "normal");
        // EEPROM over straps, keep set then clear
        s = '0;
        {s.port2_speed_sel, s.port2_duplex_sel} = 2'b11;
        {s.missing_link_en, s.port1_force_pause, s.port2_force_pause} = '1;
        an <= 2'b01;
        for (k = 0; k < 2; k++) begin
            s.strap_override_keep = !k;
            do_reset(s);
            @(posedge clk);
            ee <= ~s;
            ee_valid <= 1'b1;
            @(posedge clk);
            ee_valid <= 1'b0;
            repeat (3) @(negedge clk);
            chk({port2_cfg.autoneg_en, port2_cfg.duplex_full, missing_link_en,
                port1_cfg.autoneg_en}, k ? 4'h9 : 4'h7, "ee");
            chk({port1_cfg.pause_en, port2_cfg.pause_en}, 2'b10,
                "pz");
        end
        close_out();
    end
endmodule
